// file: design/dcb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dcb_top #(
  parameter int unsigned WIDTH = dcb_pkg::DATA_WIDTH
) (
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire logic                       wr_en,
  input  wire logic [3:0]                 wr_sel,
  input  wire logic [4:0]                 wr_chan,
  input  wire logic [15:0]                wr_data,
  input  wire logic                       load_strobe_n,
  output logic                            wr_ready,
  output logic [dcb_pkg::NUM_CHANNELS*16-1:0] dac_words,
  output logic [13:0]                     group0_offset_level,
  output logic [13:0]                     upper_groups_offset_level,
  output logic                            thermal_shutdown_en,
  output logic                            soft_power_down,
  output logic [31:0]                     source_select
);
  localparam int unsigned N = dcb_pkg::NUM_CHANNELS;

  // Math is fixed at 16 bits; the check still accepts WIDTH 14 as well as 16
  if (WIDTH != 16 && WIDTH != 14) begin : g_width_check
    $error("dcb_top: WIDTH must be 16 or 14");
  end

  // ==========================================================
  // Host-written storage and engine-written calibrated words
  logic [15:0] primary_input_word   [N];
  logic [15:0] alternate_input_word [N];
  logic [15:0] gain_trim_word       [N];
  logic [15:0] offset_trim_word     [N];
  logic [15:0] primary_cal          [N];
  logic [15:0] alternate_cal        [N];
  logic [13:0] group0_offset_level_reg, group0_offset_level_next, upper_groups_offset_level_reg, upper_groups_offset_level_next;
  logic [2:0]  ctrl_reg, ctrl_next;
  logic [31:0] absel_reg, absel_next;
  logic        bank;

  // Pending calibration, one outstanding at a time
  logic        pend_reg,  pend_next;
  logic [4:0]  pchan_reg, pchan_next;
  logic        pbank_reg, pbank_next;
  logic        ldn_d_reg;
  logic        load;

  dcb_req_if req ();

  assign bank     = ctrl_reg[dcb_pkg::CTRL_BANK_BIT];
  // Writes wait while a calc is in flight, so trims stay stable
  assign wr_ready = ~pend_reg;

  // ==========================================================
  // Control, offset-level and select registers
  always_comb begin
    group0_offset_level_next  = group0_offset_level_reg;
    upper_groups_offset_level_next  = upper_groups_offset_level_reg;
    ctrl_next  = ctrl_reg;
    absel_next = absel_reg;
    if (wr_en && wr_ready) begin
      case (wr_sel)
        dcb_pkg::SEL_GROUP0_OFFSET_LEVEL:      group0_offset_level_next = wr_data[13:0];
        dcb_pkg::SEL_UPPER_GROUPS_OFFSET_LEVEL:      upper_groups_offset_level_next = wr_data[13:0];
        dcb_pkg::SEL_CONTROL:   ctrl_next = wr_data[2:0];
        dcb_pkg::SEL_ABSEL:     absel_next[wr_chan[1:0]*8 +: 8] = wr_data[7:0];
        dcb_pkg::SEL_ABSEL_ALL: absel_next = {32{wr_data[0]}};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      group0_offset_level_reg  <= dcb_pkg::OFS_RESET_CODE;
      upper_groups_offset_level_reg  <= dcb_pkg::OFS_RESET_CODE;
      ctrl_reg  <= dcb_pkg::CTRL_RESET;
      absel_reg <= '0;
    end else begin
      group0_offset_level_reg  <= group0_offset_level_next;
      upper_groups_offset_level_reg  <= upper_groups_offset_level_next;
      ctrl_reg  <= ctrl_next;
      absel_reg <= absel_next;
    end
  end

  // ==========================================================
  // Per-channel words; data writes steered by bank bit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        primary_input_word[i]   <= dcb_pkg::INPUT_RESET_CODE;
        alternate_input_word[i] <= dcb_pkg::INPUT_RESET_CODE;
        gain_trim_word[i]       <= dcb_pkg::GAIN_RESET_CODE;
        offset_trim_word[i]     <= dcb_pkg::OFFSET_RESET_CODE;
        primary_cal[i]          <= '0;
        alternate_cal[i]        <= '0;
      end
    end else begin
      if (wr_en && wr_ready) begin
        case (wr_sel)
          dcb_pkg::SEL_PRIMARY: begin
            if (bank) alternate_input_word[wr_chan] <= wr_data;
            else primary_input_word[wr_chan] <= wr_data;
          end
          dcb_pkg::SEL_GAIN:   gain_trim_word[wr_chan]   <= wr_data;
          dcb_pkg::SEL_OFFSET: offset_trim_word[wr_chan] <= wr_data;
          default: ;
        endcase
      end
      // Only the engine writes calibrated words
      if (req.done) begin
        if (pbank_reg) alternate_cal[pchan_reg] <= req.result;
        else primary_cal[pchan_reg] <= req.result;
      end
    end
  end

  // ==========================================================
  // Recompute trigger and request to shared unit
  always_comb begin
    pend_next  = pend_reg;
    pchan_next = pchan_reg;
    pbank_next = pbank_reg;
    if (req.done) pend_next = 1'b0;
    if (wr_en && wr_ready && (wr_sel == dcb_pkg::SEL_PRIMARY || wr_sel == dcb_pkg::SEL_GAIN
                               || wr_sel == dcb_pkg::SEL_OFFSET)) begin
      pend_next  = 1'b1;
      pchan_next = wr_chan;
      pbank_next = bank;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_reg  <= 1'b0;
      pchan_reg <= '0;
      pbank_reg <= 1'b0;
      ldn_d_reg <= 1'b1;
    end else begin
      pend_reg  <= pend_next;
      pchan_reg <= pchan_next;
      pbank_reg <= pbank_next;
      ldn_d_reg <= load_strobe_n;
    end
  end

  // Issue exactly once: the cycle after the write
  logic issue_reg;
  always_ff @(posedge clock) begin
    if (sys_rst) issue_reg <= 1'b0;
    else issue_reg <= pend_next & ~pend_reg;
  end

  assign req.valid   = issue_reg;
  assign req.chan    = pchan_reg;
  assign req.bank    = pbank_reg;
  assign req.in_word = pbank_reg ? alternate_input_word[pchan_reg] : primary_input_word[pchan_reg];
  assign req.gain    = gain_trim_word[pchan_reg];
  assign req.offset  = offset_trim_word[pchan_reg];

  // One multiplier and adder for all channels
  dcb_cal_unit #(.WIDTH(16)) u_cal (
    .clock   (clock),
    .sys_rst (sys_rst),
    .req     (req)
  );

  // ==========================================================
  // Falling edge of load strobe updates all channels together
  assign load = ldn_d_reg & ~load_strobe_n;

  // Groups of eight share a select register
  for (genvar c = 0; c < N; c++) begin : g_chan
    dcb_abmux #(.WIDTH(16)) u_mux (
      .clock         (clock),
      .sys_rst       (sys_rst),
      .load          (load),
      .sel_alt       (absel_reg[c]),
      .primary_cal   (primary_cal[c]),
      .alternate_cal (alternate_cal[c]),
      .dac_word      (dac_words[c*16 +: 16])  // Output only
    );
  end

  assign group0_offset_level       = group0_offset_level_reg;
  assign upper_groups_offset_level = upper_groups_offset_level_reg;
  assign thermal_shutdown_en       = ctrl_reg[dcb_pkg::CTRL_TSHUT_BIT];
  assign soft_power_down           = ctrl_reg[dcb_pkg::CTRL_PDOWN_BIT];
  assign source_select             = absel_reg;

  // ==========================================================
  // Assertions
  // Accepted data-word write
  sequence s_data_write;
    wr_en && wr_ready && wr_sel == dcb_pkg::SEL_PRIMARY;
  endsequence

  // Accepted gain or offset trim write
  sequence s_trim_write;
    wr_en && wr_ready && (wr_sel == dcb_pkg::SEL_GAIN || wr_sel == dcb_pkg::SEL_OFFSET);
  endsequence

  // One pass through the shared unit: issue, then result
  sequence s_calc_pass;
    req.valid ##1 req.done;
  endsequence

  recompute_start_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_data_write |=> pend_reg ##0 s_calc_pass)
    else $error("recompute did not run after data write");

  // Trim writes recompute the word of the current bank
  trim_recompute_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_trim_write |=> (pbank_reg == $past(bank)) ##0 s_calc_pass)
    else $error("recompute did not run after trim write");

  load_copy_a: assert property (@(posedge clock) disable iff (sys_rst)
    load |=> dac_words[15:0] == ($past(absel_reg[0]) ? $past(alternate_cal[0]) : $past(primary_cal[0])))
    else $error("channel 0 not loaded from selected word");

  ofs_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(wr_en && wr_ready && wr_sel == dcb_pkg::SEL_GROUP0_OFFSET_LEVEL) |=> $stable(group0_offset_level_reg))
    else $error("offset level changed without write");

  select_all_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_en && wr_ready && wr_sel == dcb_pkg::SEL_ABSEL_ALL |=> source_select == {32{$past(wr_data[0])}})
    else $error("global select command failed");

  single_unit_a: assert property (@(posedge clock) disable iff (sys_rst)
    req.valid |-> !wr_ready)
    else $error("write accepted while calculation in flight");

  bank_steer_a: assert property (@(posedge clock) disable iff (sys_rst)
    (s_data_write and bank) |=> primary_input_word[$past(wr_chan)] == $past(primary_input_word[wr_chan]))
    else $error("bank 1 write reached primary word");

  dac_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    !load |=> $stable(dac_words))
    else $error("final words changed without load");

  power_bits_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_en && wr_ready && wr_sel == dcb_pkg::SEL_CONTROL |=> soft_power_down == $past(wr_data[0]))
    else $error("power-down bit not taken");

  ofs_reset_a: assert property (@(posedge clock)
    $fell(sys_rst) |-> upper_groups_offset_level_reg == dcb_pkg::OFS_RESET_CODE)
    else $error("offset level reset value wrong");

  // Host must get the port back once the result is stored
  ready_return_a: assert property (@(posedge clock) disable iff (sys_rst)
    req.done |=> wr_ready)
    else $error("write port still blocked after result");

  // Result lands in the word of the bank it was issued for
  primary_store_a: assert property (@(posedge clock) disable iff (sys_rst)
    req.done && !pbank_reg |=> primary_cal[$past(pchan_reg)] == $past(req.result))
    else $error("primary calibrated word not stored");

  alternate_store_a: assert property (@(posedge clock) disable iff (sys_rst)
    req.done && pbank_reg |=> alternate_cal[$past(pchan_reg)] == $past(req.result))
    else $error("alternate calibrated word not stored");

  // Calibrated words move only through the shared unit
  cal_hidden_a: assert property (@(posedge clock) disable iff (sys_rst)
    !req.done |=> $stable(primary_cal[0]) && $stable(alternate_cal[0]))
    else $error("calibrated word changed without recompute");

  // Thermal enable follows control bit 1
  tshut_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_en && wr_ready && wr_sel == dcb_pkg::SEL_CONTROL |=> thermal_shutdown_en == $past(wr_data[1]))
    else $error("thermal enable bit not taken");

  // Group write sets its own eight select bits from the low data byte
  group_select_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_en && wr_ready && wr_sel == dcb_pkg::SEL_ABSEL |=>
      source_select[$past(wr_chan[1:0])*8 +: 8] == $past(wr_data[7:0]))
    else $error("group select register not written");

  // Upper groups level takes the low fourteen bits
  upper_groups_offset_level_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_en && wr_ready && wr_sel == dcb_pkg::SEL_UPPER_GROUPS_OFFSET_LEVEL |=> upper_groups_offset_level == $past(wr_data[13:0]))
    else $error("upper groups offset level not written");
endmodule : dcb_top
`default_nettype wire

// file: design/dcb_pkg.sv
package dcb_pkg;
  // ==========================================================
  // Geometry
  localparam int unsigned NUM_GROUPS     = 4;
  localparam int unsigned GROUP_SIZE     = 8;
  localparam int unsigned NUM_CHANNELS   = 32;
  localparam int unsigned DATA_WIDTH     = 16;
  localparam int unsigned OFS_WIDTH      = 14;
  localparam int unsigned CTRL_WIDTH     = 3;
  localparam int unsigned CHAN_IDX_WIDTH = 5;
  // ==========================================================
  // Register selects on the write port
  localparam logic [3:0] SEL_PRIMARY   = 4'h0;
  localparam logic [3:0] SEL_GAIN      = 4'h1;
  localparam logic [3:0] SEL_OFFSET    = 4'h2;
  localparam logic [3:0] SEL_GROUP0_OFFSET_LEVEL      = 4'h3;
  localparam logic [3:0] SEL_UPPER_GROUPS_OFFSET_LEVEL      = 4'h4;
  localparam logic [3:0] SEL_CONTROL   = 4'h5;
  localparam logic [3:0] SEL_ABSEL     = 4'h6;
  localparam logic [3:0] SEL_ABSEL_ALL = 4'h7;
  // ==========================================================
  // Control register fields
  localparam int unsigned CTRL_PDOWN_BIT = 0;
  localparam int unsigned CTRL_TSHUT_BIT = 1;
  localparam int unsigned CTRL_BANK_BIT  = 2;
  // ==========================================================
  // Reset values
  localparam logic [13:0] OFS_RESET_CODE    = 14'h1555;
  localparam logic [15:0] INPUT_RESET_CODE  = 16'h5554;
  localparam logic [15:0] GAIN_RESET_CODE   = 16'hffff;
  localparam logic [15:0] OFFSET_RESET_CODE = 16'h8000;
  localparam logic [2:0]  CTRL_RESET        = 3'h0;
endpackage : dcb_pkg

// file: design/dcb_req_if.sv
`timescale 1ns/1ns
`default_nettype none
// Request interface between top and calibration engine
interface dcb_req_if;
  logic        valid;
  logic        ready;
  logic [4:0]  chan;
  logic        bank;
  logic [15:0] in_word;
  logic [15:0] gain;
  logic [15:0] offset;
  logic        done;
  logic [15:0] result;
  modport master (output valid, chan, bank, in_word, gain, offset, input ready, done, result);
  modport slave  (input valid, chan, bank, in_word, gain, offset, output ready, done, result);
endinterface : dcb_req_if
`default_nettype wire

// file: design/dcb_cal_unit.sv
`timescale 1ns/1ns
`default_nettype none
// Shared multiply-add: result one cycle after valid, one request at a time
module dcb_cal_unit #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  dcb_req_if.slave  req
);
  logic              done_reg,   done_next;
  logic [WIDTH-1:0]  result_reg, result_next;
  logic [2*WIDTH:0]  prod;
  logic signed [2*WIDTH+2:0] sum;

  // ==========================================================
  // Single multiplier and single adder
  always_comb begin
    prod = {1'b0, req.in_word} * ({1'b0, req.gain} + 17'h00001);
    sum  = $signed({2'b00, prod[2*WIDTH:WIDTH]}) + $signed({19'h00000, req.offset})
           - $signed({3'b000, 1'b1, {(WIDTH-1){1'b0}}});
    done_next   = req.valid;
    result_next = result_reg;
    // Saturate instead of wrapping
    if (req.valid) begin
      if (sum < 0) result_next = '0;
      else if (sum > $signed({3'b000, {WIDTH{1'b1}}})) result_next = '1;
      else result_next = sum[WIDTH-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_reg   <= 1'b0;
      result_reg <= '0;
    end else begin
      done_reg   <= done_next;
      result_reg <= result_next;
    end
  end

  assign req.ready  = 1'b1;
  assign req.done   = done_reg;
  assign req.result = result_reg;
endmodule : dcb_cal_unit
`default_nettype wire

// file: design/dcb_abmux.sv
`timescale 1ns/1ns
`default_nettype none
// One channel's final register with source select
module dcb_abmux #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic             sel_alt,
  input  wire logic [WIDTH-1:0] primary_cal,
  input  wire logic [WIDTH-1:0] alternate_cal,
  output logic      [WIDTH-1:0] dac_word
);
  logic [WIDTH-1:0] dac_reg, dac_next;

  // Copy the chosen calibrated word on load
  always_comb begin
    dac_next = dac_reg;
    if (load) dac_next = sel_alt ? alternate_cal : primary_cal;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) dac_reg <= '0;
    else dac_reg <= dac_next;
  end

  assign dac_word = dac_reg;
endmodule : dcb_abmux
`default_nettype wire

// file: verif/dcb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Host side of the register write port
module dcb_host_model (
  input  wire logic        clock,
  input  wire logic        wr_ready,
  output logic             wr_en,
  output logic [3:0]       wr_sel,
  output logic [4:0]       wr_chan,
  output logic [15:0]      wr_data,
  output logic             load_strobe_n
);
  // Idle values from time zero
  initial begin
    wr_en         = 1'b0;
    wr_sel        = 4'h0;
    wr_chan       = 5'h00;
    wr_data       = 16'h0000;
    load_strobe_n = 1'b1;
  end

  // Request held until an edge with ready high takes it
  task automatic write(input logic [3:0] sel, input logic [4:0] chan, input logic [15:0] data);
    @(negedge clock);
    wr_en   = 1'b1;
    wr_sel  = sel;
    wr_chan = chan;
    wr_data = data;
    // Offset levels kept inside the 5 V code range
    if ((sel == dcb_pkg::SEL_GROUP0_OFFSET_LEVEL || sel == dcb_pkg::SEL_UPPER_GROUPS_OFFSET_LEVEL) && data > 16'h2000) begin
      wr_data = 16'h2000;
    end
    while (!wr_ready) @(negedge clock);
    @(negedge clock);
    wr_en   = 1'b0;
    wr_data = ~wr_data;  // Stale data must not look valid
  endtask : write

  // Strobe low after any recompute, so the load sees fresh words
  task automatic load();
    @(negedge clock);
    while (!wr_ready) @(negedge clock);
    load_strobe_n = 1'b0;
    repeat (3) @(negedge clock);
    load_strobe_n = 1'b1;
  endtask : load
endmodule : dcb_host_model
`default_nettype wire

// file: verif/dac_channel_calibration_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Self-checking bench for the calibration bank
module dac_channel_calibration_bank_tb;
  logic          clock;
  logic          sys_rst;
  logic          wr_en;
  logic [3:0]    wr_sel;
  logic [4:0]    wr_chan;
  logic [15:0]   wr_data;
  logic          load_strobe_n;
  logic          wr_ready;
  logic [511:0]  dac_words;
  logic [13:0]   group0_offset_level;
  logic [13:0]   upper_groups_offset_level;
  logic          thermal_shutdown_en;
  logic          soft_power_down;
  logic [31:0]   source_select;
  int            n_fail;
  int            tests_run;

  // Clock and reset level at time zero
  initial begin
    clock     = 1'b0;
    sys_rst   = 1'b1;
    n_fail    = 0;
    tests_run = 0;
    forever #5 clock = ~clock;
  end

  dcb_top u_dcb_top (
    .clock                     (clock),
    .sys_rst                   (sys_rst),
    .wr_en                     (wr_en),
    .wr_sel                    (wr_sel),
    .wr_chan                   (wr_chan),
    .wr_data                   (wr_data),
    .load_strobe_n             (load_strobe_n),
    .wr_ready                  (wr_ready),
    .dac_words                 (dac_words),
    .group0_offset_level       (group0_offset_level),
    .upper_groups_offset_level (upper_groups_offset_level),
    .thermal_shutdown_en       (thermal_shutdown_en),
    .soft_power_down           (soft_power_down),
    .source_select             (source_select)
  );

  dcb_host_model u_dcb_host_model (
    .clock         (clock),
    .wr_ready      (wr_ready),
    .wr_en         (wr_en),
    .wr_sel        (wr_sel),
    .wr_chan       (wr_chan),
    .wr_data       (wr_data),
    .load_strobe_n (load_strobe_n)
  );

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [15:0] dac(input int c);
    return dac_words[16*c +: 16];
  endfunction : dac

  // Reference math, clipped rather than wrapped
  function automatic logic [15:0] cal(input logic [15:0] x, input logic [15:0] g, input logic [15:0] o);
    longint t;
    t = (longint'(x) * (longint'(g) + 1)) / 65536 + longint'(o) - 32768;
    if (t < 0) t = 0;
    if (t > 65535) t = 65535;
    return 16'(t);
  endfunction : cal

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    chk(group0_offset_level, 14'h1555);
    chk(upper_groups_offset_level, 14'h1555);
    chk({thermal_shutdown_en, soft_power_down}, 2'h0);
    chk(source_select, 32'h0);
    chk(dac(5), 16'h0);
    u_dcb_host_model.write(dcb_pkg::SEL_PRIMARY, 5'd5, 16'h1234);
    chk(wr_ready, 1'b0);
    u_dcb_host_model.load();
    chk(dac(5), cal(16'h1234, 16'hffff, 16'h8000));
    u_dcb_host_model.write(dcb_pkg::SEL_GAIN, 5'd5, 16'h7fff);
    u_dcb_host_model.load();
    chk(dac(5), cal(16'h1234, 16'h7fff, 16'h8000));
    u_dcb_host_model.write(dcb_pkg::SEL_CONTROL, 5'd0, 16'h0007);
    chk({thermal_shutdown_en, soft_power_down}, 2'h3);
    u_dcb_host_model.write(dcb_pkg::SEL_PRIMARY, 5'd9, 16'habcd);
    u_dcb_host_model.write(dcb_pkg::SEL_ABSEL_ALL, 5'd0, 16'h0001);
    chk(source_select, 32'hffffffff);
    u_dcb_host_model.load();
    chk(dac(9), cal(16'habcd, 16'hffff, 16'h8000));
    chk(dac(5), 16'h0);
    u_dcb_host_model.write(dcb_pkg::SEL_OFFSET, 5'd9, 16'hffff);
    u_dcb_host_model.load();
    chk(dac(9), cal(16'habcd, 16'hffff, 16'hffff));
    u_dcb_host_model.write(dcb_pkg::SEL_ABSEL, 5'd1, 16'h00fd);
    chk(source_select, 32'hfffffdff);
    u_dcb_host_model.load();
    chk(dac(9), 16'h0);
    u_dcb_host_model.write(dcb_pkg::SEL_GROUP0_OFFSET_LEVEL, 5'd0, 16'h2000);
    u_dcb_host_model.write(dcb_pkg::SEL_UPPER_GROUPS_OFFSET_LEVEL, 5'd0, 16'h0abc);
    chk(group0_offset_level, 14'h2000);
    chk(upper_groups_offset_level, 14'h0abc);
    u_dcb_host_model.write(dcb_pkg::SEL_ABSEL_ALL, 5'd0, 16'h0000);
    chk(source_select, 32'h0);
    u_dcb_host_model.write(dcb_pkg::SEL_CONTROL, 5'd0, 16'h0000);
    chk({thermal_shutdown_en, soft_power_down}, 2'h0);
    tally_and_finish();
  end

  // Watchdog well beyond the roughly 70 cycles the run needs
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : dac_channel_calibration_bank_tb
`default_nettype wire
